// file: logic/frp_pkg.sv
package frp_pkg;

	// register byte offsets
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_STAT   = 5'h04;
	localparam logic [4:0] OFS_OPA_HI = 5'h08;
	localparam logic [4:0] OFS_OPA_LO = 5'h0c;
	localparam logic [4:0] OFS_OPB    = 5'h10;
	localparam logic [4:0] OFS_CMD    = 5'h14;
	localparam logic [4:0] OFS_RES_HI = 5'h18;
	localparam logic [4:0] OFS_RES_LO = 5'h1c;

	typedef enum logic [1:0] {
		round_nearest_mode,
		round_toward_zero_mode,
		round_toward_plus_inf_mode,
		round_toward_minus_inf_mode
	} frp_mode_type;

	typedef enum logic [2:0] {fmt_byte, fmt_word, fmt_long, fmt_single, fmt_double} frp_fmt_type;
	typedef enum logic [1:0] {op_finish, op_load, op_store} frp_op_type;
	typedef enum logic [1:0] {rounding_precision_field_from_ctrl, rounding_precision_field_single, rounding_precision_field_double} frp_rounding_precision_field_type;

	// fp_control_register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_ROUNDING_PRECISION_FIELD_BIT = 2;
	localparam int CTRL_IDE_BIT  = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;

	// command fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_FMT_LSB  = 2;
	localparam int CMD_ROUNDING_PRECISION_FIELD_LSB = 5;

	// fp_status_register: exception_status_byte, accrued_exception_byte
	localparam int EXC_INEXACT_FLAG     = 0;
	localparam int EXC_UNDERFLOW_FLAG     = 1;
	localparam int EXC_OVERFLOW_FLAG     = 2;
	localparam int EXC_IDN      = 3;
	localparam int STAT_ACC_LSB = 8;
	localparam int STAT_BUSY    = 16;
	localparam int STAT_TRAP    = 17;
	localparam logic [3:0] EXC_RST = 4'h0;

	// exponent ranges, 12-bit two's complement unbiased
	localparam logic signed [11:0] BIAS_D = 12'h3ff;
	localparam logic signed [11:0] BIAS_S = 12'h07f;
	localparam logic signed [11:0] EMIN_D = 12'hc02;
	localparam logic signed [11:0] EMAX_D = 12'h3ff;
	localparam logic signed [11:0] EMIN_S = 12'hf82;
	localparam logic signed [11:0] EMAX_S = 12'h07f;
	localparam logic [51:0] LARGEST_S_FRAC = 52'hf_ffff_e000_0000;

	// largest integer magnitudes
	localparam logic [32:0] LIM_B = 33'h0_0000_007f;
	localparam logic [32:0] LIM_W = 33'h0_0000_7fff;
	localparam logic [32:0] LIM_L = 33'h0_7fff_ffff;

endpackage

// file: logic/frp_round_inc.sv
`timescale 1ns/1ps
`default_nettype none
module frp_round_inc
	import frp_pkg::*;
#(
	parameter int W = 53
)
(
	input  wire logic [W-1:0]  keep,
	input  wire logic          guard,
	input  wire logic          rnd,
	input  wire logic          sticky,
	input  wire logic          sign,
	input  wire frp_mode_type  mode,
	output logic      [W:0]    sum,
	output logic               inexact,
	output logic               inc
);
	always_comb
	begin
		inexact = guard | rnd | sticky;
		case (mode)
			round_nearest_mode:          inc = guard & (rnd | sticky | keep[0]);
			round_toward_zero_mode:      inc = 1'b0;
			round_toward_plus_inf_mode:  inc = ~sign & inexact;
			round_toward_minus_inf_mode: inc = sign & inexact;
			default:                     inc = 1'b0;
		endcase
		sum = {1'b0, keep} + {{W{1'b0}}, inc};
	end
endmodule
`default_nettype wire

// file: logic/frp_unit.sv
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module frp_unit
	import frp_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);
	logic        [3:0]  ctrl_q;
	logic        [3:0]  exc_q;
	logic        [3:0]  acc_q;
	logic               trap_q;
	logic        [31:0] opa_hi_q;
	logic        [31:0] opa_lo_q;
	logic        [31:0] opb_q;
	logic        [7:0]  cmd_q;
	logic        [31:0] res_hi_q;
	logic        [31:0] res_lo_q;
	logic               go_q;
	logic               done_q;
	logic               wait_q;
	logic        [31:0] rdata_q;

	logic               take;
	logic               wr;
	logic               busy;
	frp_op_type         cmd_op;
	frp_fmt_type        cmd_fmt;
	frp_rounding_precision_field_type       cmd_rounding_precision_field;
	frp_mode_type       mode;

	assign busy     = go_q | done_q;
	assign take     = (avs_read | avs_write) & wait_q & ~busy;
	assign wr       = avs_write & ~wait_q;
	assign cmd_op   = frp_op_type'(cmd_q[CMD_OP_LSB +: 2]);
	assign cmd_fmt  = frp_fmt_type'(cmd_q[CMD_FMT_LSB +: 3]);
	assign cmd_rounding_precision_field = frp_rounding_precision_field_type'(cmd_q[CMD_ROUNDING_PRECISION_FIELD_LSB +: 2]);
	assign mode     = frp_mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
	assign avs_waitrequest = wait_q;
	assign avs_readdata    = rdata_q;

	// bus slave: one wait cycle, longer while an operation is in flight
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0;
		end
		else
		begin
			wait_q <= ~take;
			if (take & avs_read)
			begin
				case (avs_address)
					OFS_CTRL:   rdata_q <= {28'h0, ctrl_q};
					OFS_STAT:   rdata_q <= {14'h0, trap_q, busy, 4'h0, acc_q, 4'h0, exc_q};
					OFS_OPA_HI: rdata_q <= opa_hi_q;
					OFS_OPA_LO: rdata_q <= opa_lo_q;
					OFS_OPB:    rdata_q <= opb_q;
					OFS_CMD:    rdata_q <= {24'h0, cmd_q};
					OFS_RES_HI: rdata_q <= res_hi_q;
					OFS_RES_LO: rdata_q <= res_lo_q;
					default:    rdata_q <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ctrl_q   <= CTRL_RST;
			opa_hi_q <= 32'h0;
			opa_lo_q <= 32'h0;
			opb_q    <= 32'h0;
			cmd_q    <= 8'h0;
			go_q     <= 1'b0;
		end
		else
		begin
			go_q <= wr & (avs_address == OFS_CMD);
			if (wr & (avs_address == OFS_CTRL))
				ctrl_q <= avs_writedata[3:0];
			if (wr & (avs_address == OFS_OPA_HI))
				opa_hi_q <= avs_writedata;
			if (wr & (avs_address == OFS_OPA_LO))
				opa_lo_q <= avs_writedata;
			if (wr & (avs_address == OFS_OPB))
				opb_q <= avs_writedata;
			if (wr & (avs_address == OFS_CMD))
				cmd_q <= avs_writedata[7:0];
		end
	end

	// stage 0: build the intermediate (sign, 12-bit exponent, 56-bit mantissa)
	logic               s0_sign;
	logic signed [11:0] s0_exp;
	logic        [55:0] s0_mant;
	logic               s0_stk;
	logic               s0_zero;
	logic               s0_spec;
	logic               s0_denorm;
	logic               s0_single;
	logic        [31:0] ival;
	logic        [31:0] mag;
	logic        [4:0]  lead;

	always_comb
	begin
		s0_sign   = opa_hi_q[31];
		s0_exp    = 12'(opa_hi_q[30:20]) - BIAS_D;
		s0_mant   = {1'b1, opa_hi_q[19:0], opa_lo_q, 3'h0};
		s0_stk    = 1'b0;
		s0_zero   = (opa_hi_q[30:20] == 11'h0) & ({opa_hi_q[19:0], opa_lo_q} == 52'h0);
		s0_spec   = (opa_hi_q[30:20] == 11'h7ff);
		s0_denorm = (opa_hi_q[30:20] == 11'h0) & ~s0_zero;
		s0_single = 1'b0;
		ival      = opa_lo_q;
		mag       = 32'h0;
		lead      = 5'h0;
		case (cmd_op)
			op_finish:
			begin
				s0_sign   = opb_q[31];
				s0_exp    = opb_q[27:16];
				s0_mant   = {opa_hi_q[23:0], opa_lo_q};
				s0_stk    = opb_q[0];
				s0_zero   = (s0_mant == 56'h0) & ~s0_stk;
				s0_spec   = 1'b0;
				s0_denorm = 1'b0;
				s0_single = (cmd_rounding_precision_field == rounding_precision_field_single) |
					((cmd_rounding_precision_field == rounding_precision_field_from_ctrl) & ctrl_q[CTRL_ROUNDING_PRECISION_FIELD_BIT]);
			end
			op_load:
			begin
				if (cmd_fmt == fmt_single)
				begin
					s0_sign   = opa_lo_q[31];
					s0_exp    = 12'(opa_lo_q[30:23]) - BIAS_S;
					s0_mant   = {1'b1, opa_lo_q[22:0], 32'h0};
					s0_zero   = (opa_lo_q[30:0] == 31'h0);
					s0_spec   = (opa_lo_q[30:23] == 8'hff);
					s0_denorm = (opa_lo_q[30:23] == 8'h0) & ~s0_zero;
				end
				else if (cmd_fmt != fmt_double)
				begin
					case (cmd_fmt)
						fmt_byte: ival = {{24{opa_lo_q[7]}}, opa_lo_q[7:0]};
						fmt_word: ival = {{16{opa_lo_q[15]}}, opa_lo_q[15:0]};
						default:  ival = opa_lo_q;
					endcase
					mag = ival[31] ? (32'h0 - ival) : ival;
					for (int i = 0; i < 32; i++)
						if (mag[i])
							lead = 5'(i);
					s0_sign   = ival[31];
					s0_exp    = {7'h0, lead};
					s0_mant   = {mag, 24'h0} << (5'd31 - lead);
					s0_zero   = (mag == 32'h0);
					s0_spec   = 1'b0;
					s0_denorm = 1'b0;
				end
			end
			default:
				s0_single = (cmd_fmt == fmt_single);
		endcase
		if (s0_denorm & ~ctrl_q[CTRL_IDE_BIT])
			s0_zero = 1'b1;
	end

	logic               i_sign_q;
	logic signed [11:0] i_exp_q;
	logic        [55:0] i_mant_q;
	logic               i_stk_q;
	logic               i_zero_q;
	logic               i_spec_q;
	logic               i_trap_q;
	logic               i_single_q;
	logic               i_int_q;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			i_sign_q   <= 1'b0;
			i_exp_q    <= 12'h0;
			i_mant_q   <= 56'h0;
			i_stk_q    <= 1'b0;
			i_zero_q   <= 1'b0;
			i_spec_q   <= 1'b0;
			i_trap_q   <= 1'b0;
			i_single_q <= 1'b0;
			i_int_q    <= 1'b0;
			done_q     <= 1'b0;
		end
		else
		begin
			done_q <= go_q;
			if (go_q)
			begin
				i_sign_q   <= s0_sign;
				i_exp_q    <= s0_exp;
				i_mant_q   <= s0_mant;
				i_stk_q    <= s0_stk;
				i_zero_q   <= s0_zero;
				i_spec_q   <= s0_spec;
				i_trap_q   <= s0_denorm & ctrl_q[CTRL_IDE_BIT];
				i_single_q <= s0_single;
				i_int_q    <= (cmd_op == op_store) & (cmd_fmt < fmt_single);
			end
		end
	end

	// stage 1: underflow check, round, overflow check
	logic signed [11:0] emin;
	logic signed [11:0] emax;
	logic signed [11:0] sa;
	logic signed [11:0] exp_r;
	logic        [5:0]  nr;
	logic        [127:0] base;
	logic        [127:0] v;
	logic               lost;
	logic               big;
	logic        [52:0] r_keep;
	logic               r_g;
	logic               r_r;
	logic               r_s;
	logic        [53:0] r_sum;
	logic               r_inexact_flag;
	logic        [51:0] frac;
	logic        [10:0] bexp;
	logic               underflow_flag;
	logic               overflow_flag;
	logic               inexact_flag;
	logic               to_inf;
	logic        [63:0] dres;
	logic        [32:0] ilim;
	logic        [31:0] ires;

	assign base = {64'h0, i_mant_q, 8'h0};
	assign sa   = i_exp_q + 12'sh001;

	always_comb
	begin
		v    = 128'h0;
		lost = 1'b0;
		big  = 1'b0;
		nr   = 6'h0;
		if (sa > 12'sh020)
			big = 1'b1;
		else if (!sa[11])
			v = base << sa[5:0];
		else if ((12'sh000 - sa) > 12'sh03f)
			lost = (i_mant_q != 56'h0);
		else
		begin
			nr   = 6'(12'sh000 - sa);
			v    = base >> nr;
			lost = |(base & ((128'h1 << nr) - 128'h1));
		end
		if (i_int_q)
		begin
			r_keep = {21'h0, v[95:64]};
			r_g    = v[63];
			r_r    = v[62];
			r_s    = (|v[61:0]) | lost | i_stk_q;
		end
		else if (i_single_q)
		begin
			r_keep = {29'h0, i_mant_q[55:32]};
			r_g    = i_mant_q[31];
			r_r    = i_mant_q[30];
			r_s    = (|i_mant_q[29:0]) | i_stk_q;
		end
		else
		begin
			r_keep = i_mant_q[55:3];
			r_g    = i_mant_q[2];
			r_r    = i_mant_q[1];
			r_s    = i_mant_q[0] | i_stk_q;
		end
	end

	frp_round_inc #(
		.W (53)
	) u_round (
		.keep    (r_keep),
		.guard   (r_g),
		.rnd     (r_r),
		.sticky  (r_s),
		.sign    (i_sign_q),
		.mode    (mode),
		.sum     (r_sum),
		.inexact (r_inexact_flag),
		.inc     ()
	);

	always_comb
	begin
		emin   = i_single_q ? EMIN_S : EMIN_D;
		emax   = i_single_q ? EMAX_S : EMAX_D;
		to_inf = (mode == round_nearest_mode) |
			((mode == round_toward_plus_inf_mode) & ~i_sign_q) |
			((mode == round_toward_minus_inf_mode) & i_sign_q);
		underflow_flag   = 1'b0;
		overflow_flag   = 1'b0;
		inexact_flag   = r_inexact_flag;
		if (i_single_q)
		begin
			exp_r = i_exp_q + {11'h0, r_sum[24]};
			frac  = {r_sum[22:0], 29'h0};
		end
		else
		begin
			exp_r = i_exp_q + {11'h0, r_sum[53]};
			frac  = r_sum[51:0];
		end
		bexp = 11'(exp_r + BIAS_D);
		if (i_zero_q)
		begin
			dres = {i_sign_q, 63'h0};
			inexact_flag = 1'b0;
		end
		else if (i_spec_q)
		begin
			dres = {i_sign_q, 11'h7ff, i_mant_q[54:3]};
			inexact_flag = 1'b0;
		end
		else if (i_exp_q < emin)
		begin
			underflow_flag = 1'b1;
			inexact_flag = 1'b1;
			if (to_inf & (mode != round_nearest_mode))
				dres = {i_sign_q, 11'(emin + BIAS_D), 52'h0};
			else
				dres = {i_sign_q, 63'h0};
		end
		else if (exp_r > emax)
		begin
			overflow_flag = 1'b1;
			inexact_flag = 1'b1;
			if (to_inf)
				dres = {i_sign_q, 11'h7ff, 52'h0};
			else
				dres = {i_sign_q, 11'(emax + BIAS_D),
					i_single_q ? LARGEST_S_FRAC : {52{1'b1}}};
		end
		else
			dres = {i_sign_q, bexp, frac};
		case (cmd_fmt)
			fmt_byte: ilim = LIM_B;
			fmt_word: ilim = LIM_W;
			default:  ilim = LIM_L;
		endcase
		ires = i_sign_q ? (32'h0 - r_sum[31:0]) : r_sum[31:0];
		if (i_int_q)
		begin
			underflow_flag = 1'b0;
			overflow_flag = ~i_zero_q & (big | ({12'h0, r_sum[52:32]} != 33'h0) |
				({1'b0, r_sum[31:0]} > (ilim + {32'h0, i_sign_q})));
			inexact_flag = (r_inexact_flag & ~i_zero_q) | overflow_flag;
			if (i_zero_q)
				ires = 32'h0;
			else if (overflow_flag)
				ires = i_sign_q ? (32'hffff_ffff - ilim[31:0]) : ilim[31:0];
		end
	end

	// result and flags; a status write and a completing op in one cycle: the op wins in exc_q, set wins in acc_q and trap_q
	logic [3:0] new_exc;
	logic       st_wr;

	assign st_wr   = wr & (avs_address == OFS_STAT);
	assign new_exc = {1'b0, overflow_flag, underflow_flag, inexact_flag};

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			res_hi_q <= 32'h0;
			res_lo_q <= 32'h0;
		end
		else if (done_q & ~i_trap_q)
		begin
			if (i_int_q)
			begin
				res_hi_q <= {32{ires[31]}};
				res_lo_q <= ires;
			end
			else if (cmd_op == op_store & cmd_fmt == fmt_single)
			begin
				res_hi_q <= 32'h0;
				res_lo_q <= {dres[63], (dres[62:52] == 11'h7ff) ? 8'hff :
					(dres[62:52] == 11'h0) ? 8'h00 : 8'(dres[62:52] - 11'h380),
					dres[51:29]};
			end
			else
			begin
				res_hi_q <= dres[63:32];
				res_lo_q <= dres[31:0];
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			exc_q  <= EXC_RST;
			acc_q  <= EXC_RST;
			trap_q <= 1'b0;
		end
		else
		begin
			if (go_q)
				exc_q <= EXC_RST;
			else if (done_q)
				exc_q <= i_trap_q ? 4'h8 : new_exc;
			else if (st_wr)
				exc_q <= avs_writedata[3:0];
			if (done_q & ~i_trap_q)
				acc_q <= (st_wr ? avs_writedata[STAT_ACC_LSB +: 4] : acc_q) |
					{1'b0, overflow_flag, underflow_flag & inexact_flag, inexact_flag};
			else if (st_wr)
				acc_q <= avs_writedata[STAT_ACC_LSB +: 4];
			if (done_q & i_trap_q)
				trap_q <= 1'b1;
			else if (st_wr & avs_writedata[STAT_TRAP])
				trap_q <= 1'b0;
		end
	end

	a_bus_answer: assert property (@(posedge ref_clk) disable iff (rst)
		take |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle after take");
	a_op_latency: assert property (@(posedge ref_clk) disable iff (rst)
		go_q |=> done_q ##1 !busy)
		else $error("operation did not finish in two cycles");
	a_rz_trunc: assert property (@(posedge ref_clk) disable iff (rst)
		(mode == round_toward_zero_mode) |-> r_sum[52:0] == r_keep)
		else $error("toward zero changed the kept bits");
	a_rn_tie: assert property (@(posedge ref_clk) disable iff (rst)
		(mode == round_nearest_mode && r_g && !r_r && !r_s && !r_keep[0])
		|-> r_sum[52:0] == r_keep)
		else $error("tie rounded away from even");
	a_dir_side: assert property (@(posedge ref_clk) disable iff (rst)
		(mode == round_toward_plus_inf_mode && i_sign_q) |-> r_sum[52:0] == r_keep)
		else $error("plus rounding grew a negative value");
	a_overflow_flag_flag: assert property (@(posedge ref_clk) disable iff (rst)
		(done_q && !i_trap_q && overflow_flag) |=> exc_q[EXC_OVERFLOW_FLAG] && exc_q[EXC_INEXACT_FLAG] && acc_q[EXC_OVERFLOW_FLAG])
		else $error("overflow not flagged");
	a_acc_sticky: assert property (@(posedge ref_clk) disable iff (rst)
		(acc_q[EXC_INEXACT_FLAG] && !st_wr) |=> acc_q[EXC_INEXACT_FLAG])
		else $error("accrued inexact dropped");
	a_denorm_trap: assert property (@(posedge ref_clk) disable iff (rst)
		(go_q && s0_denorm && ctrl_q[CTRL_IDE_BIT]) |=> ##1 trap_q && exc_q[EXC_IDN])
		else $error("denormal trap missing");
	a_denorm_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(go_q && s0_denorm && !ctrl_q[CTRL_IDE_BIT] && cmd_op == op_load) |=> ##1
		res_hi_q[30:0] == 31'h0 && res_lo_q == 32'h0)
		else $error("denormal not flushed to zero");
	a_inf_form: assert property (@(posedge ref_clk) disable iff (rst)
		(done_q && !i_int_q && overflow_flag && to_inf) |-> dres[62:0] == {11'h7ff, 52'h0})
		else $error("overflow infinity malformed");
endmodule
`default_nettype wire

// file: testbench/frp_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module frp_pipe_model
(
	input  wire logic        ref_clk,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output var logic  [4:0]  avs_address,
	output var logic         avs_read,
	output var logic         avs_write,
	output var logic  [31:0] avs_writedata
);
	initial
	begin
		avs_address   = 5'h00;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
	end

	// one bus transfer, held until waitrequest is seen low
	task automatic xfer(input logic wr_en, input logic [4:0] addr, input logic [31:0] data,
		output logic [31:0] rdata);
		@(posedge ref_clk);
		avs_address   <= addr;
		avs_writedata <= data;
		avs_write     <= wr_en;
		avs_read      <= ~wr_en;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge ref_clk);
		rdata = avs_readdata;
		avs_read      <= 1'b0;
		avs_write     <= 1'b0;
		// released data must not look valid
		avs_writedata <= ~data;
	endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import frp_pkg::*;
;
	typedef struct packed {
		logic [3:0]  ctrl;
		logic [6:0]  cmd;
		logic [31:0] ahi;
		logic [31:0] alo;
		logic [31:0] opb;
		logic [31:0] rhi;
		logic [31:0] rlo;
		logic [3:0]  sm;
		logic [3:0]  sv;
	} frp_row_type;

	// ctrl, cmd, operand hi/lo, opb, result hi/lo, status mask, status value
	localparam frp_row_type ROWS [25] = '{
		'{4'h0, 7'h10, 32'h800000, 32'h0, 32'h0, 32'h3ff00000, 32'h0, 4'hf, 4'h0},
		'{4'h0, 7'h10, 32'h800000, 32'h4, 32'h0, 32'h3ff00000, 32'h0, 4'hf, 4'h1},
		'{4'h0, 7'h10, 32'h800000, 32'hc, 32'h0, 32'h3ff00000, 32'h2, 4'hf, 4'h1},
		'{4'h1, 7'h10, 32'h800000, 32'hf, 32'h0, 32'h3ff00000, 32'h1, 4'hf, 4'h1},
		'{4'h2, 7'h10, 32'h800000, 32'h1, 32'h0, 32'h3ff00000, 32'h1, 4'hf, 4'h1},
		'{4'h2, 7'h10, 32'h800000, 32'h1, 32'h80000000, 32'hbff00000, 32'h0, 4'hf, 4'h1},
		'{4'h3, 7'h10, 32'h800000, 32'h1, 32'h80000000, 32'hbff00000, 32'h1, 4'hf, 4'h1},
		'{4'h0, 7'h10, 32'h800000, 32'h0, 32'h1, 32'h3ff00000, 32'h0, 4'hf, 4'h1},
		'{4'h4, 7'h10, 32'h800000, 32'h80000000, 32'h0, 32'h3ff00000, 32'h0, 4'hf, 4'h1},
		'{4'h0, 7'h30, 32'h800000, 32'h80000001, 32'h0, 32'h3ff00000, 32'h20000000, 4'hf, 4'h1},
		'{4'h4, 7'h50, 32'h800000, 32'h80000000, 32'h0, 32'h3ff00000, 32'h10000000, 4'hf, 4'h0},
		'{4'h0, 7'h10, 32'h800000, 32'h0, 32'h0fff0000, 32'h3fe00000, 32'h0, 4'hf, 4'h0},
		'{4'h7, 7'h10, 32'h800000, 32'h0, 32'h00800000, 32'h47efffff, 32'he0000000, 4'h4, 4'h4},
		'{4'h0, 7'h10, 32'h800000, 32'h0, 32'h04000000, 32'h7ff00000, 32'h0, 4'h4, 4'h4},
		'{4'h1, 7'h10, 32'h800000, 32'h0, 32'h84000000, 32'hffefffff, 32'hffffffff, 4'h4, 4'h4},
		'{4'h0, 7'h10, 32'hffffff, 32'hffffffff, 32'h03ff0000, 32'h7ff00000, 32'h0, 4'h4, 4'h4},
		'{4'h0, 7'h10, 32'h800000, 32'h0, 32'h0c010000, 32'h0, 32'h0, 4'h2, 4'h2},
		'{4'h0, 7'h0e, 32'h3ff00000, 32'h10000001, 32'h0, 32'h0, 32'h3f800001, 4'hf, 4'h1},
		'{4'h4, 7'h0a, 32'h40040000, 32'h0, 32'h0, 32'h0, 32'h2, 4'hf, 4'h1},
		'{4'h0, 7'h06, 32'hc0000000, 32'h0, 32'h0, 32'hffffffff, 32'hfffffffe, 4'hf, 4'h0},
		'{4'h0, 7'h02, 32'h4072c000, 32'h0, 32'h0, 32'h0, 32'h7f, 4'h4, 4'h4},
		'{4'h0, 7'h12, 32'h3ff80000, 32'h5, 32'h0, 32'h3ff80000, 32'h5, 4'hf, 4'h0},
		'{4'h0, 7'h0d, 32'h0, 32'h3f800000, 32'h0, 32'h3ff00000, 32'h0, 4'hf, 4'h0},
		'{4'h0, 7'h09, 32'h0, 32'hffffffff, 32'h0, 32'hbff00000, 32'h0, 4'hf, 4'h0},
		'{4'h0, 7'h11, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 4'h8, 4'h0}
	};

	logic        ref_clk;
	logic        rst;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	int          failures;
	int          cmp_count;
	int          cycles;
	logic [31:0] v;

	frp_unit dut_u (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest)
	);

	frp_pipe_model pipe_u (
		.ref_clk         (ref_clk),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata)
	);

	initial
	begin
		ref_clk = 1'b0;
		rst     = 1'b1;
	end

	always #5 ref_clk = ~ref_clk;

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// bench hang guard
	always @(posedge ref_clk)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			failures = failures + 1;
			conclude();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		pipe_u.xfer(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		pipe_u.xfer(1'b0, a, 32'h0, d);
	endtask

	task automatic run_row(input frp_row_type r);
		wr(OFS_CTRL, {28'h0, r.ctrl});
		wr(OFS_OPA_HI, r.ahi);
		wr(OFS_OPA_LO, r.alo);
		wr(OFS_OPB, r.opb);
		wr(OFS_CMD, {25'h0, r.cmd});
	endtask

	initial
	begin
		failures  = 0;
		cmp_count = 0;
		cycles    = 0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 25; i++)
		begin
			run_row(ROWS[i]);
			rd(OFS_RES_HI, v);
			chk("res_hi", ROWS[i].rhi, v);
			rd(OFS_RES_LO, v);
			chk("res_lo", ROWS[i].rlo, v);
			rd(OFS_STAT, v);
			chk("stat", {28'h0, ROWS[i].sv}, {28'h0, v[3:0] & ROWS[i].sm});
			$display("test row %0d done", i);
		end

		// denormal with trap enabled leaves the result alone
		wr(OFS_CTRL, 32'h0);
		wr(OFS_OPA_HI, 32'h3ff00000);
		wr(OFS_OPA_LO, 32'h0);
		wr(OFS_CMD, 32'h11);
		wr(OFS_CTRL, 32'h8);
		wr(OFS_OPA_HI, 32'h0);
		wr(OFS_OPA_LO, 32'h1);
		wr(OFS_CMD, 32'h11);
		rd(OFS_RES_HI, v);
		chk("trap_res", 32'h3ff00000, v);
		rd(OFS_STAT, v);
		chk("trap_stat", 32'h00020008, v & 32'h00020008);
		wr(OFS_STAT, 32'h00020000);
		rd(OFS_STAT, v);
		chk("trap_clear", 32'h0, v & 32'h00020000);
		$display("test trap done");

		// accrued inexact stays set after a later exact op
		wr(OFS_STAT, 32'h0);
		for (int k = 0; k < 3; k++)
		begin
			run_row(ROWS[k % 2]);
			rd(OFS_STAT, v);
			chk("accrued", {23'h0, k != 0, 7'h0, k == 1}, v & 32'h101);
		end
		$display("test accrued done");

		// second reset in mid-run
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		chk("wait_in_reset", 32'h1, {31'h0, avs_waitrequest});
		chk("rdata_in_reset", 32'h0, avs_readdata);
		rd(OFS_CTRL, v);
		chk("ctrl_reset", 32'h0, v);
		rd(OFS_STAT, v);
		chk("stat_reset", 32'h0, v);
		$display("test reset done");
		conclude();
	end
endmodule
`default_nettype wire
